// file: hw/cxsm_top.sv
// Transceiver mode controller with supply monitor and APB registers
`timescale 1ns/1ps
`include "cxsm_map.svh"
module cxsm_top #(
    parameter int unsigned STARTUP_CYC = `CXSM_STARTUP_US * `CXSM_CLK_MHZ,
    parameter int unsigned SILENCE_CYC = `CXSM_SILENCE_US * `CXSM_CLK_MHZ
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [11:0]      paddr,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             bat_ok_pin,
    input  wire logic             bat_can_uv_pin,
    input  wire logic             overtemp_pin,
    input  wire logic [3:0]       supply_uv_pin,
    input  wire cxsm_pkg::cxsm_sel_t startup_threshold_default,
    input  wire logic [2:0]       sbc_mode_sel,
    input  wire logic             tx_data_in,
    input  wire logic             bus_rx_pin,
    input  wire logic             bus_wake_pin,
    output logic                  rx_data_out,
    output logic                  tx_drive_en,
    output logic                  bias_mid,
    output logic                  bias_gnd,
    output logic                  xcvr_powered,
    output logic                  sys_reset_req,
    output logic                  sbc_off
);
    import cxsm_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    logic [9:0] raw_w;
    logic [9:0] syn_w;
    // Bus and transmit idle high: carried inverted so the chains reset
    // to idle and no false bus edge follows reset
    assign raw_w = {bus_wake_pin, !bus_rx_pin, !tx_data_in, overtemp_pin,
                    bat_can_uv_pin, bat_ok_pin, supply_uv_pin};

    cxsm_sync #(.W(10)) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (raw_w),
        .sync_out (syn_w)
    );

    wire [3:0] uv_s   = syn_w[3:0];  // 0:90 1:80 2:70 3:60
    wire       bat_s  = syn_w[4];
    wire       bcuv_s = syn_w[5];
    wire       otp_s  = syn_w[6];
    wire       txd_s  = !syn_w[7];
    wire       rx_s   = !syn_w[8];
    wire       wake_s = syn_w[9];

    logic bus_edge_w;
    logic silent_w;

    cxsm_silence #(.LIMIT(SILENCE_CYC)) u_sil (
        .pclk     (pclk),
        .presetn  (presetn),
        .bus_s    (rx_s),
        .bus_edge (bus_edge_w),
        .silent   (silent_w)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    cxsm_pwr_e   pwr_q, pwr_d;
    cxsm_xcvr_e  xst_q, xst_d;
    logic [31:0] start_cnt_q;
    cxsm_sel_t   thr_q;
    cxsm_sel_t   mode_q;
    logic        load_q;
    logic        warn_en_q, wake_en_q;
    logic        pu_ev_q, warn_ev_q, wake_ev_q;
    logic        uv90_prev_q;
    logic        wake_prev_q;

    // ------------------------------------------------------------
    // Supply decode
    // ------------------------------------------------------------
    wire uv90_w    = uv_s[0];
    wire uvsel_w   = uv_s[thr_q];
    wire run_w     = (pwr_q == P_RUN);
    wire start_end = (pwr_q == P_START) &&
                     (start_cnt_q >= STARTUP_CYC - 1);
    wire dead_w    = !run_w || bcuv_s || otp_s;
    wire normal_w  = run_w && !uvsel_w &&
                     (sbc_mode_sel == `CXSM_SBC_NORMAL);
    wire sel00_w   = (mode_q == 2'h0);
    wire sel01_w   = (mode_q == 2'h1);
    wire sel10_w   = (mode_q == 2'h2);
    wire sel11_w   = (mode_q == 2'h3);
    // Active only above the threshold that fits the encoding
    wire act_ok_w  = normal_w && ((sel01_w && !uv90_w) ||
                                  (sel10_w && !uvsel_w));
    wire lsn_req_w = normal_w && (sel11_w || (sel01_w && uv90_w) ||
                                  (act_ok_w && !txd_s));
    wire drop_w    = !normal_w || sel00_w ||
                     (sel10_w && uvsel_w);
    wire wake_hit  = wake_s && !wake_prev_q && wake_en_q &&
                     (xst_q == X_OFFLINE);
    cxsm_xcvr_e offsel_w;
    assign offsel_w = silent_w ? X_OFFLINE : X_OFFBIAS;

    // ------------------------------------------------------------
    // Power sequencing
    // ------------------------------------------------------------
    always_comb begin
        pwr_d = pwr_q;
        unique case (pwr_q)
            P_OFF:   if (bat_s) pwr_d = P_START;
            P_START: if (start_end) pwr_d = P_RUN;
            P_RUN:   pwr_d = P_RUN;
        endcase
        if (!bat_s)
            pwr_d = P_OFF;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pwr_q <= P_OFF;
        else
            pwr_q <= pwr_d;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            start_cnt_q <= 32'h00000000;
        else if (pwr_q == P_START)
            start_cnt_q <= start_cnt_q + 32'h00000001;
        else
            start_cnt_q <= 32'h00000000;
    end

    // ------------------------------------------------------------
    // Transceiver mode machine
    // ------------------------------------------------------------
    always_comb begin
        xst_d = xst_q;
        unique case (xst_q)
            X_OFF:
                xst_d = X_OFFLINE;
            X_OFFLINE, X_OFFBIAS: begin
                if (act_ok_w && txd_s)
                    xst_d = X_ACTIVE;
                else if (lsn_req_w && !(sel01_w && uv90_w))
                    xst_d = X_LISTEN;
                else if (xst_q == X_OFFLINE) begin
                    if (bus_edge_w || wake_hit ||
                        (normal_w && sel01_w && uv90_w))
                        xst_d = X_OFFBIAS;
                end else if (silent_w &&
                             !(normal_w && sel01_w && uv90_w))
                    xst_d = X_OFFLINE;
            end
            X_LISTEN: begin
                if (drop_w)
                    xst_d = offsel_w;
                else if (act_ok_w && txd_s)
                    xst_d = X_ACTIVE;
            end
            X_ACTIVE: begin
                if (drop_w || (sel01_w && uv90_w))
                    xst_d = offsel_w;
                else if (sel11_w)
                    xst_d = X_LISTEN;
            end
            default:
                xst_d = X_OFF;
        endcase
        if (dead_w)
            xst_d = X_OFF;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            xst_q <= X_OFF;
        else
            xst_q <= xst_d;
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    wire on_bus_w = (xst_q == X_ACTIVE) || (xst_q == X_LISTEN);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_drive_en   <= 1'b0;
            bias_mid      <= 1'b0;
            bias_gnd      <= 1'b0;
            xcvr_powered  <= 1'b0;
            rx_data_out   <= 1'b1;
            sys_reset_req <= 1'b1;
            sbc_off       <= 1'b1;
        end else begin
            tx_drive_en   <= (xst_q == X_ACTIVE);
            bias_mid      <= on_bus_w || (xst_q == X_OFFBIAS);
            bias_gnd      <= (xst_q == X_OFFLINE);
            xcvr_powered  <= (xst_q != X_OFF);
            rx_data_out   <= on_bus_w ? rx_s : !wake_ev_q;
            sys_reset_req <= !run_w || uvsel_w;
            sbc_off       <= (pwr_q == P_OFF);
        end
    end

    // ------------------------------------------------------------
    // APB slave, one wait-free access phase
    // ------------------------------------------------------------
    wire [9:0] idx_w   = paddr[11:2];
    wire       setup_w = psel && !penable;
    wire       wr_w    = psel && penable && pready && pwrite;
    wire hit_thr  = (idx_w == `CXSM_IDX_THR_CTRL);
    wire hit_sup  = (idx_w == `CXSM_IDX_SUP_STAT);
    wire hit_can  = (idx_w == `CXSM_IDX_CAN_CTRL);
    wire hit_xs   = (idx_w == `CXSM_IDX_XCVR_STAT);
    wire hit_ev   = (idx_w == `CXSM_IDX_EVT_STAT);
    wire hit_en   = (idx_w == `CXSM_IDX_EVT_EN);
    wire mapped_w = hit_thr || hit_sup || hit_can || hit_xs ||
                    hit_ev || hit_en;
    wire ev_clr_w = wr_w && hit_ev;

    wire [31:0] xs_w  = {24'h000000, (xst_q == X_ACTIVE), 3'h0,
                         silent_w, 1'b0, sel01_w && uv90_w, 1'b0};
    wire [31:0] rd_w  =
        hit_thr ? {30'h00000000, thr_q} :
        hit_sup ? {31'h00000000, uv90_w} :
        hit_can ? {30'h00000000, mode_q} :
        hit_xs  ? xs_w :
        hit_ev  ? {29'h00000000, wake_ev_q, warn_ev_q, pu_ev_q} :
        hit_en  ? {30'h00000000, wake_en_q, warn_en_q} :
                  32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup_w;
            pslverr <= setup_w && !mapped_w;
            prdata  <= (setup_w && !pwrite) ? rd_w : 32'h00000000;
        end
    end

    // Load from the non-volatile default after reset and each power-up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_q <= 1'b1;
            thr_q  <= 2'h0;
        end else begin
            load_q <= 1'b0;
            if (load_q || start_end)
                thr_q <= startup_threshold_default;
            else if (wr_w && hit_thr)
                thr_q <= pwdata[`CXSM_THR_LSB +: 2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q    <= `CXSM_MODE_RST;
            warn_en_q <= 1'b0;
            wake_en_q <= 1'b0;
        end else begin
            if (wr_w && hit_can)
                mode_q <= pwdata[`CXSM_MODE_LSB +: 2];
            if (wr_w && hit_en) begin
                warn_en_q <= pwdata[`CXSM_EN_WARN_BIT];
                wake_en_q <= pwdata[`CXSM_EN_WAKE_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Events: set beats a write-one clear in the same cycle
    // ------------------------------------------------------------
    wire warn_set = run_w && uv90_w && !uv90_prev_q && warn_en_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            uv90_prev_q <= 1'b0;
            wake_prev_q <= 1'b0;
            pu_ev_q     <= 1'b0;
            warn_ev_q   <= 1'b0;
            wake_ev_q   <= 1'b0;
        end else begin
            uv90_prev_q <= uv90_w;
            wake_prev_q <= wake_s;
            pu_ev_q   <= start_end ||
                         (pu_ev_q && !(ev_clr_w && pwdata[`CXSM_EV_PU_BIT]));
            warn_ev_q <= warn_set || (warn_ev_q &&
                         !(ev_clr_w && pwdata[`CXSM_EV_WARN_BIT]));
            wake_ev_q <= wake_hit || (wake_ev_q &&
                         !(ev_clr_w && pwdata[`CXSM_EV_WAKE_BIT]));
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    batt_off_a: assert property
        (!bat_s |=> pwr_q == P_OFF ##1 sbc_off)
        else $error("battery loss did not enter off mode");
    startup_end_a: assert property (start_end |=> run_w && pu_ev_q)
        else $error("start-up end did not set power-up event");
    reset_req_a: assert property (run_w && uvsel_w |=> sys_reset_req)
        else $error("supply below threshold without reset request");
    warn_event_a: assert property (warn_set |=> warn_ev_q)
        else $error("supply warning not captured");
    mid_bias_a: assert property (on_bus_w |=> bias_mid && !bias_gnd)
        else $error("mid bias missing on bus modes");
    txd_block_a: assert property
        (xst_q != X_ACTIVE && !txd_s |=> xst_q != X_ACTIVE)
        else $error("active entered with transmit input low");
    uv_leave_a: assert property (xst_q == X_ACTIVE && sel01_w && uv90_w
        |=> xst_q inside {X_OFFLINE, X_OFFBIAS, X_OFF})
        else $error("active kept below 90 percent");
    dead_off_a: assert property
        (dead_w |=> xst_q == X_OFF ##1 !xcvr_powered)
        else $error("transceiver not off when unpowered");
    listen_tx_a: assert property (xst_q == X_LISTEN |=> !tx_drive_en)
        else $error("transmitter on in listen-only");
    wake_rx_a: assert property
        (wake_hit |=> wake_ev_q ##1 !rx_data_out)
        else $error("wake-up did not pull receive output low");

    active_c: cover property (xst_q == X_LISTEN ##1 xst_q == X_ACTIVE);
    wake_c:   cover property (wake_hit);
    warn_c:   cover property (warn_set);
    bias_c:   cover property (xst_q == X_OFFBIAS ##1 xst_q == X_OFFLINE);
endmodule

// file: hw/cxsm_map.svh
// Register map, field positions, reset values and timing counts
`ifndef CXSM_MAP_SVH
`define CXSM_MAP_SVH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define CXSM_IDX_THR_CTRL   10'h010
`define CXSM_IDX_SUP_STAT   10'h01B
`define CXSM_IDX_CAN_CTRL   10'h020
`define CXSM_IDX_XCVR_STAT  10'h022
`define CXSM_IDX_EVT_STAT   10'h030
`define CXSM_IDX_EVT_EN     10'h031

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CXSM_THR_LSB        0
`define CXSM_SUPLOW_BIT     0
`define CXSM_MODE_LSB       0
`define CXSM_XS_ACTIVE_BIT  7
`define CXSM_XS_SILENT_BIT  3
`define CXSM_XS_UV_BIT      1
`define CXSM_EV_PU_BIT      0
`define CXSM_EV_WARN_BIT    1
`define CXSM_EV_WAKE_BIT    2
`define CXSM_EN_WARN_BIT    0
`define CXSM_EN_WAKE_BIT    1

// ------------------------------------------------------------
// Reset values and codes
// ------------------------------------------------------------
`define CXSM_MODE_RST       2'h0
`define CXSM_EN_RST         2'h0
`define CXSM_SBC_NORMAL     3'h7
`define CXSM_SBC_STANDBY    3'h4

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CXSM_CLK_MHZ        200
`define CXSM_STARTUP_US     100
`define CXSM_SILENCE_US     1000

`endif

// file: hw/cxsm_pkg.sv
// Types shared by the transceiver mode and supply monitor block
package cxsm_pkg;

    typedef enum logic [2:0] {
        X_OFF,
        X_OFFLINE,
        X_OFFBIAS,
        X_LISTEN,
        X_ACTIVE
    } cxsm_xcvr_e;

    typedef enum logic [1:0] {
        P_OFF,
        P_START,
        P_RUN
    } cxsm_pwr_e;

    typedef logic [1:0] cxsm_sel_t;

endpackage

// file: hw/cxsm_sync.sv
// Two-flop synchroniser, one chain per bit
`timescale 1ns/1ps
module cxsm_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                meta_q[i]   <= 1'b0;
                sync_out[i] <= 1'b0;
            end else begin
                meta_q[i]   <= async_in[i];
                sync_out[i] <= meta_q[i];
            end
        end
    end
endmodule

// file: hw/cxsm_silence.sv
// Bus edge detector and silence timer
`timescale 1ns/1ps
module cxsm_silence #(
    parameter int unsigned LIMIT = 200000
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic bus_s,
    output logic      bus_edge,
    output logic      silent
);
    logic        prev_q;
    logic [31:0] cnt_q;
    wire         edge_w = bus_s ^ prev_q;
    wire         full_w = (cnt_q > LIMIT);

    // Starts silent so a drop out of listen or active before any bus edge goes to grounded bias
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 1'b1;
            cnt_q  <= 32'hFFFFFFFF;
        end else begin
            prev_q <= bus_s;
            if (edge_w)
                cnt_q <= 32'h00000000;
            else if (!full_w)
                cnt_q <= cnt_q + 32'h00000001;
        end
    end

    assign bus_edge = edge_w;
    assign silent   = full_w;
endmodule

// file: testbench/cxsm_host_ctrl.sv
// Host protocol controller model driving the transmit pin
`timescale 1ns/1ps
module cxsm_host_ctrl (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic hold_low,
    input  wire logic rx_data_out,
    output logic      tx_data_in,
    output logic      rx_low_seen
);
    // Recessive while idle, as a real controller after its own reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_data_in  <= 1'b1;
            rx_low_seen <= 1'b0;
        end else begin
            tx_data_in <= ~hold_low;
            if (!rx_data_out) begin
                rx_low_seen <= 1'b1;
            end
        end
    end
endmodule

// file: testbench/cxsm_bench.sv
// Self-checking bench for the transceiver mode and supply monitor
`timescale 1ns/1ps
`include "cxsm_map.svh"
module cxsm_bench;
    import cxsm_pkg::*;
    localparam logic [9:0] THR = `CXSM_IDX_THR_CTRL;
    localparam logic [9:0] SUP = `CXSM_IDX_SUP_STAT;
    localparam logic [9:0] CAN = `CXSM_IDX_CAN_CTRL;
    localparam logic [9:0] XS  = `CXSM_IDX_XCVR_STAT;
    localparam logic [9:0] EVT = `CXSM_IDX_EVT_STAT;
    localparam logic [9:0] EN  = `CXSM_IDX_EVT_EN;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        bat_ok, can_uv, otemp, tx, brx, bwake, hold;
    logic        rxo, txen, bmid, bgnd, pwr, rreq, off, seen;
    logic [3:0]  uv;
    logic [2:0]  sbc;
    cxsm_sel_t   thr_def;
    int          fails, samples_checked, cyc;

    cxsm_top #(.STARTUP_CYC(8), .SILENCE_CYC(20)) dut_u (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bat_ok_pin(bat_ok), .bat_can_uv_pin(can_uv),
        .overtemp_pin(otemp), .supply_uv_pin(uv),
        .startup_threshold_default(thr_def), .sbc_mode_sel(sbc),
        .tx_data_in(tx), .bus_rx_pin(brx), .bus_wake_pin(bwake),
        .rx_data_out(rxo), .tx_drive_en(txen), .bias_mid(bmid),
        .bias_gnd(bgnd), .xcvr_powered(pwr), .sys_reset_req(rreq),
        .sbc_off(off));
    cxsm_host_ctrl host_u (.pclk(pclk), .presetn(presetn),
        .hold_low(hold), .rx_data_out(rxo), .tx_data_in(tx),
        .rx_low_seen(seen));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic g, input logic e, input string m);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask
    task automatic chkr(input logic [31:0] g, input logic [31:0] e,
                        input string m);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("FAIL %0t %s got %h", $time, m, g);
        end
    endtask
    task automatic st(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Waits on pready itself; only the cycle ceiling ends a hang
    task automatic apb(input logic w, input logic [9:0] i,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {i, 2'b00};
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [9:0] i, input logic [31:0] m,
                       input logic [31:0] e, input string s);
        apb(1'b0, i, 32'h0);
        chkr(rd & m, e, s);
    endtask
    task automatic pins(input logic t, input logic m, input logic g,
                        input string s);
        chk(txen, t, s);
        chk(bmid, m, s);
        chk(bgnd, g, s);
    endtask
    task automatic mode(input logic [1:0] m);
        apb(1'b1, CAN, {30'h0, m});
        st(8);
    endtask
    task automatic edges(input int n, input int gap);
        repeat (n) begin
            st(gap);
            brx <= ~brx;
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // Whole run is under a thousand cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            $display("FAIL %0t timeout", $time);
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {bat_ok, can_uv, otemp, uv, bwake, hold} = '0;
        thr_def = 2'h2;
        sbc = `CXSM_SBC_NORMAL;
        brx = 1'b1;
        fails = 0;
        samples_checked = 0;
        cyc = 0;
        st(5);
        presetn <= 1'b1;
        st(3);
        chk(off, 1'b1, "off at reset");
        chk(pwr, 1'b0, "floating");
        bat_ok <= 1'b1;
        st(40);
        chk(off, 1'b0, "running");
        pins(1'b0, 1'b0, 1'b1, "offline at start");
        chk(rreq, 1'b0, "no reset");
        chk(seen, 1'b0, "receive high at start");
        rdc(EVT, 32'h1, 32'h1, "power up event");
        rdc(THR, 32'h3, 32'h2, "threshold default");
        apb(1'b1, EVT, 32'h7);
        $display("power_up done");
        uv <= 4'h1;
        st(8);
        uv <= 4'h0;
        st(8);
        rdc(EVT, 32'h2, 32'h0, "warn masked");
        apb(1'b1, EN, 32'h1);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, THR, 32'(i));
            uv <= 4'((1 << i) - 1);
            st(8);
            chk(rreq, 1'b0, "above threshold");
            rdc(SUP, 32'h1, 32'(i != 0), "supply low");
            uv <= 4'((2 << i) - 1);
            st(8);
            chk(rreq, 1'b1, "below threshold");
        end
        rdc(EVT, 32'h2, 32'h2, "warn event");
        apb(1'b1, EVT, 32'h2);
        rdc(EVT, 32'h2, 32'h0, "warn cleared");
        apb(1'b1, SUP, 32'h0);
        rdc(SUP, 32'h1, 32'h1, "status read only");
        apb(1'b0, 10'h3FF, 32'h0);
        chk(err, 1'b1, "unmapped error");
        chkr(rd, 32'h0, "unmapped data");
        uv <= 4'h0;
        st(8);
        $display("supply done");
        mode(2'h2);
        pins(1'b1, 1'b1, 1'b0, "active 10");
        rdc(XS, 32'h80, 32'h80, "active flag");
        brx <= 1'b0;
        st(6);
        chk(rxo, 1'b0, "receive follows bus");
        brx <= 1'b1;
        uv <= 4'h7;
        st(8);
        chk(txen, 1'b1, "above 60 percent");
        uv <= 4'hF;
        st(8);
        chk(txen, 1'b0, "below 60 percent");
        uv <= 4'h0;
        mode(2'h1);
        pins(1'b1, 1'b1, 1'b0, "active 01");
        uv <= 4'h1;
        st(8);
        chk(txen, 1'b0, "01 leaves below 90");
        rdc(XS, 32'h2, 32'h2, "below 90 flag");
        uv <= 4'h0;
        st(8);
        chk(txen, 1'b1, "01 back above 90");
        mode(2'h3);
        pins(1'b0, 1'b1, 1'b0, "listen");
        uv <= 4'h1;
        mode(2'h1);
        pins(1'b0, 1'b1, 1'b0, "held listen");
        uv <= 4'h0;
        st(8);
        chk(txen, 1'b1, "listen released");
        mode(2'h3);
        hold <= 1'b1;
        mode(2'h2);
        pins(1'b0, 1'b1, 1'b0, "transmit low");
        hold <= 1'b0;
        st(8);
        pins(1'b1, 1'b1, 1'b0, "transmit high");
        $display("modes done");
        edges(2, 4);
        mode(2'h0);
        pins(1'b0, 1'b1, 1'b0, "bias after active");
        rdc(XS, 32'h8, 32'h0, "bus busy");
        st(30);
        pins(1'b0, 1'b0, 1'b1, "offline by silence");
        rdc(XS, 32'h8, 32'h8, "bus silent");
        edges(6, 15);
        pins(1'b0, 1'b1, 1'b0, "timer restarted");
        st(30);
        mode(2'h2);
        sbc <= `CXSM_SBC_STANDBY;
        st(8);
        pins(1'b0, 1'b0, 1'b1, "standby offline");
        mode(2'h0);
        sbc <= `CXSM_SBC_NORMAL;
        apb(1'b1, EN, 32'h2);
        // Wake pattern carries bus edges, which keep the bias up
        bwake <= 1'b1;
        brx   <= 1'b0;
        st(2);
        bwake <= 1'b0;
        brx   <= 1'b1;
        st(8);
        chk(rxo, 1'b0, "wake on receive");
        chk(bmid, 1'b1, "wake biases");
        chk(seen, 1'b1, "host saw receive low");
        rdc(EVT, 32'h4, 32'h4, "wake event");
        apb(1'b1, EVT, 32'h4);
        st(4);
        chk(rxo, 1'b1, "wake cleared");
        st(30);
        $display("offline done");
        can_uv <= 1'b1;
        st(8);
        chk(pwr, 1'b0, "battery low off");
        pins(1'b0, 1'b0, 1'b0, "bus floating");
        can_uv <= 1'b0;
        st(8);
        chk(pwr, 1'b1, "battery back");
        otemp <= 1'b1;
        st(8);
        chk(pwr, 1'b0, "overtemp off");
        edges(2, 3);
        otemp <= 1'b0;
        st(12);
        chk(bgnd, 1'b1, "overtemp to offline");
        apb(1'b1, THR, 32'h1);
        bat_ok <= 1'b0;
        st(8);
        chk(off, 1'b1, "battery off");
        chk(pwr, 1'b0, "off floats");
        bat_ok <= 1'b1;
        st(40);
        chk(off, 1'b0, "restart");
        rdc(EVT, 32'h1, 32'h1, "power up again");
        rdc(THR, 32'h3, 32'h2, "threshold reload");
        $display("power_cycle done");
        end_sim();
    end
endmodule
